// ### shared/sss_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH
// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define SSS_CTRL_OFS 12'h000
`define SSS_STAT_OFS 12'h004
`define SSS_CNT_OFS 12'h008
// ****************************************************************
// Control fields
// ****************************************************************
`define SSS_CTRL_RUN_BIT 0
`define SSS_CTRL_RESET 32'h0000_0000
// ****************************************************************
// Status fields
// ****************************************************************
`define SSS_STAT_REFOK_BIT 0
`define SSS_STAT_LOCK_BIT 1
`define SSS_STAT_RUN_BIT 2
`define SSS_STAT_SSDIS_BIT 3
`define SSS_STAT_STATE_LSB 4
// ****************************************************************
// Timing
// ****************************************************************
`define SSS_STARTUP_CLOCKS 32
`endif

// ### shared/sss_pkg.sv
// Types shared by the startup and shutdown sequencer.
package sss_pkg;
    typedef enum logic [1:0] {
        SSS_HALT,
        SSS_COUNT,
        SSS_RUN
    } sss_state_e;
endpackage

// ### hw/sss_startup_counter.sv
// Start-up counter that delays release of the reference-ok signal.
`timescale 1ns/100ps
`default_nettype none
module sss_startup_counter #(
    parameter int COUNT = 32,
    parameter int W = 6
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clear,
    input wire logic enable,
    output logic done,
    output logic [W-1:0] value
);
    logic [W-1:0] cnt_reg;

    // Clearing has priority so every start counts the full interval.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (clear) begin
            cnt_reg <= '0;
        end else if (enable && cnt_reg != W'(COUNT)) begin
            cnt_reg <= cnt_reg + W'(1);
        end
    end

    assign done = (cnt_reg == W'(COUNT));
    assign value = cnt_reg;
endmodule
`default_nettype wire

// ### hw/sss_sequencer.sv
// Start-up and shutdown sequencer with APB register access.
`timescale 1ns/100ps
`default_nettype none
`include "sss_regs.svh"
module sss_sequencer #(
    parameter int STARTUP_CLOCKS = `SSS_STARTUP_CLOCKS
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic undervoltage_lockout,
    input wire logic remoteOn,
    input wire logic referenceGood,
    input wire logic [5:0] driveIn,
    output logic [5:0] driveOut,
    output logic softStartDischarge,
    output logic reference_ok_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // Wide enough to hold the terminal count itself.
    localparam int CW = $clog2(STARTUP_CLOCKS + 1);

    sss_pkg::sss_state_e state_reg;
    sss_pkg::sss_state_e state_next;
    logic swRun_reg;
    logic refOkN_reg;
    logic runReq;
    logic stopNow;
    logic cntDone;
    logic [CW-1:0] cntValue;
    // Stop terms and register words, named so reads can report them.
    logic lockStop;
    logic offStop;
    logic refStop;
    logic driveStop;
    logic ctrlWrite;
    logic readSetup;
    logic addrMapped;
    logic [31:0] ctrlWord;
    logic [31:0] statusWord;
    logic [31:0] cntWord;

    // ****************************************************************
    // Start conditions
    // ****************************************************************
    // Each stop term stands alone: any one of them shuts the bridge
    // down at once, and only all three clear lets a start begin.
    assign lockStop = undervoltage_lockout;
    // A sagging reference is treated exactly like a remote off.
    assign refStop = !referenceGood;
    // Both the pin and software must request run. Lockout is its own
    // stop term ahead of the request, so a remote on seen during
    // lockout can never start the counter.
    assign runReq = remoteOn && swRun_reg;
    assign offStop = !runReq;
    assign stopNow = lockStop || offStop || refStop;

    sss_startup_counter #(
        .COUNT(STARTUP_CLOCKS),
        .W(CW)
    ) u_counter (
        .clock(clock),
        .rst(rst),
        .clear(stopNow),
        .enable(state_reg == sss_pkg::SSS_COUNT),
        .done(cntDone),
        .value(cntValue)
    );

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            // Halted: wait for every stop term to clear.
            sss_pkg::SSS_HALT: begin
                if (!stopNow) begin
                    state_next = sss_pkg::SSS_COUNT;
                end
            end
            // Counting: any stop term aborts and the count starts over.
            sss_pkg::SSS_COUNT: begin
                if (stopNow) begin
                    state_next = sss_pkg::SSS_HALT;
                end else if (cntDone) begin
                    state_next = sss_pkg::SSS_RUN;
                end
            end
            // Running: leave at once, with no counter in the way.
            sss_pkg::SSS_RUN: begin
                if (stopNow) begin
                    state_next = sss_pkg::SSS_HALT;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= sss_pkg::SSS_HALT;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            refOkN_reg <= 1'b1;
        end else begin
            // Looking at the next state lets the flag fall on the same
            // edge that enters run, and rise on the edge that leaves it.
            refOkN_reg <= (state_next != sss_pkg::SSS_RUN);
        end
    end

    assign reference_ok_n = refOkN_reg;

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // One gate term serves both outputs, so the drives and the
    // discharge switch can never disagree about being stopped.
    assign driveStop = stopNow || refOkN_reg;

    // Stop terms are combined directly so shutdown never waits a clock.
    always_comb begin
        if (driveStop) begin
            driveOut = 6'h00;
        end else begin
            driveOut = driveIn;
        end
    end

    // Discharge while halted or counting, so each start is a soft start.
    // The capacitor thus sits empty for the whole count, and the ramp
    // always begins from zero when the drives are released.
    assign softStartDischarge = driveStop;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Every access completes in its first access cycle; the sequencer
    // never has a reason to stretch a transfer.
    assign pready = 1'b1;
    assign addrMapped = paddr == `SSS_CTRL_OFS
        || paddr == `SSS_STAT_OFS || paddr == `SSS_CNT_OFS;
    // Unmapped offsets are refused, and a write there changes nothing.
    assign pslverr = psel && penable && !addrMapped;
    assign ctrlWrite = psel && penable && pwrite
        && paddr == `SSS_CTRL_OFS;
    // Read data are captured in the setup cycle so they stand, already
    // settled, through the whole access phase.
    assign readSetup = psel && !penable && !pwrite;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            swRun_reg <= 1'b0;
        end else if (ctrlWrite) begin
            swRun_reg <= pwdata[`SSS_CTRL_RUN_BIT];
        end
    end

    // ****************************************************************
    // Read words
    // ****************************************************************
    // The run bit reads back as written, not as the pin sees it.
    always_comb begin
        ctrlWord = 32'h0000_0000;
        ctrlWord[`SSS_CTRL_RUN_BIT] = swRun_reg;
    end

    // A snapshot of the live sequencer, taken at the read's setup.
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[`SSS_STAT_REFOK_BIT] = refOkN_reg;
        statusWord[`SSS_STAT_LOCK_BIT] = undervoltage_lockout;
        statusWord[`SSS_STAT_RUN_BIT] = runReq;
        statusWord[`SSS_STAT_SSDIS_BIT] = softStartDischarge;
        statusWord[`SSS_STAT_STATE_LSB+:2] = state_reg;
    end

    always_comb begin
        cntWord = 32'h0000_0000;
        cntWord[CW-1:0] = cntValue;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (readSetup) begin
            if (paddr == `SSS_CTRL_OFS) begin
                prdata <= ctrlWord;
            end else if (paddr == `SSS_STAT_OFS) begin
                prdata <= statusWord;
            end else if (paddr == `SSS_CNT_OFS) begin
                prdata <= cntWord;
            end else begin
                // Unmapped reads return zero alongside the error.
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/sss_sequencer_chk.sv
// Port-level property checker for the startup and shutdown sequencer.
`timescale 1ns/100ps
`default_nettype none
module sss_sequencer_chk #(
    parameter int STARTUP_CLOCKS = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic undervoltage_lockout,
    input wire logic remoteOn,
    input wire logic referenceGood,
    input wire logic [5:0] driveIn,
    input wire logic [5:0] driveOut,
    input wire logic softStartDischarge,
    input wire logic reference_ok_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr
);
    logic stop;
    int upCnt;
    assign stop = undervoltage_lockout || !remoteOn || !referenceGood;
    // Counts edges since the last stop term, so a short start is caught.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            upCnt <= 0;
        end else begin
            upCnt <= stop ? 0 : upCnt + 1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_lock_outs_off: assert property (undervoltage_lockout |->
        driveOut == 6'h00 && softStartDischarge) else $error("lockout out");
    a_off_drv_low: assert property (!remoteOn |->
        driveOut == 6'h00) else $error("drive on while off");
    a_off_discharge: assert property (!remoteOn |->
        softStartDischarge) else $error("no discharge while off");
    a_lock_no_run: assert property (undervoltage_lockout |=>
        reference_ok_n) else $error("running in lockout");
    a_run_passes: assert property (!reference_ok_n && !stop |->
        driveOut == driveIn) else $error("drive not passed");
    a_idle_drv_low: assert property (reference_ok_n |->
        driveOut == 6'h00) else $error("drive before start");
    a_start_delay: assert property ($fell(reference_ok_n) |->
        upCnt >= STARTUP_CLOCKS + 1) else $error("start too early");
    a_stop_fast: assert property (!remoteOn || !referenceGood |=>
        reference_ok_n) else $error("stop delayed");
    a_apb_error: assert property (psel && penable && paddr > 12'h008
        |-> pready && pslverr) else $error("unmapped not refused");
    cover property ($fell(reference_ok_n));
    cover property (undervoltage_lockout && remoteOn);
    cover property (psel && penable && pslverr);
endmodule
bind sss_sequencer sss_sequencer_chk #(.STARTUP_CLOCKS(STARTUP_CLOCKS)) chk (
    .clock(clock), .rst(rst), .undervoltage_lockout(undervoltage_lockout),
    .remoteOn(remoteOn), .referenceGood(referenceGood), .driveIn(driveIn),
    .driveOut(driveOut), .softStartDischarge(softStartDischarge),
    .reference_ok_n(reference_ok_n), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### verification/sss_power_model.sv
// Supply monitor, remote switch and modulator feeding the sequencer.
`timescale 1ns/100ps
`default_nettype none
module sss_power_model (
    input wire logic clock,
    input wire logic lockCmd,
    input wire logic onCmd,
    input wire logic goodCmd,
    output var logic undervoltage_lockout = 1'b1,
    output var logic remoteOn = 1'b0,
    output var logic referenceGood = 1'b0,
    output var logic [5:0] driveIn = 6'h15
);
    // A lone controller: no peer shares its oscillator.
    always_ff @(posedge clock) begin
        undervoltage_lockout <= lockCmd;
        remoteOn <= onCmd;
        referenceGood <= goodCmd;
        // Toggling each cycle exposes a drive path that lags by one.
        driveIn <= ~driveIn;
    end
endmodule
`default_nettype wire

// ### verification/startup_shutdown_sequencer_tb.sv
// Self-checking bench for the startup and shutdown sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "sss_regs.svh"
module startup_shutdown_sequencer_tb;
    localparam int S = 4;
    logic clock = 1'b0, rst = 1'b1, lockCmd = 1'b1, onCmd = 1'b1;
    logic goodCmd = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic lock, on, good, pready, pslverr, dis, refN, err;
    logic [5:0] dIn, dOut;
    int fail_count = 0, compares = 0, n;
    sss_power_model pm (.clock(clock), .lockCmd(lockCmd), .onCmd(onCmd),
        .goodCmd(goodCmd), .undervoltage_lockout(lock), .remoteOn(on),
        .referenceGood(good), .driveIn(dIn));
    sss_sequencer #(.STARTUP_CLOCKS(S)) dut (.clock(clock), .rst(rst),
        .undervoltage_lockout(lock), .remoteOn(on), .referenceGood(good),
        .driveIn(dIn), .driveOut(dOut), .softStartDischarge(dis),
        .reference_ok_n(refN), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    initial begin
        forever #25 clock = ~clock;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Counts edges from the one that launched the start until running.
    task waitUp();
        n = 0;
        while (refN !== 1'b0 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("startDelay", S + 2, n);
    endtask
    task end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b1, `SSS_CTRL_OFS, 32'h0000_0001);
        repeat (2 * S + 6) @(posedge clock);
        #1;
        chk("refLock", 1'b1, refN);
        chk("drvLock", 6'h00, dOut);
        lockCmd <= 1'b0;
        @(posedge clock);
        waitUp();
        chk("drvRun", dIn, dOut);
        onCmd <= 1'b0;
        @(posedge clock);
        #1;
        chk("drvOff", 6'h00, dOut);
        chk("discharge", 1'b1, dis);
        @(posedge clock);
        #1;
        chk("refOff", 1'b1, refN);
        onCmd <= 1'b1;
        repeat (3) @(posedge clock);
        onCmd <= 1'b0;
        @(posedge clock);
        onCmd <= 1'b1;
        @(posedge clock);
        waitUp();
        apb(1'b0, `SSS_CTRL_OFS, 32'h0);
        chk("ctrlRun", 32'h0000_0001, rd);
        chk("ctrlErr", 1'b0, err);
        @(posedge clock);
        apb(1'b0, `SSS_STAT_OFS, 32'h0);
        chk("status", 32'h0000_0024, rd);
        goodCmd <= 1'b0;
        @(posedge clock);
        #1;
        chk("drvRefLow", 6'h00, dOut);
        @(posedge clock);
        #1;
        chk("refRefLow", 1'b1, refN);
        goodCmd <= 1'b1;
        @(posedge clock);
        waitUp();
        apb(1'b0, 12'h00C, 32'h0);
        chk("badData", 32'h0, rd);
        chk("badErr", 1'b1, err);
        end_sim();
    end
endmodule
`default_nettype wire
